/* File: common/cssb_pkg.sv */
// Constants for the core status register and bank-3 register view
package cssb_pkg;
   // Bank-3 register addresses (9-bit data-memory addresses)
   localparam logic [8:0] ADDR_INDIRECT_DATA_PORT = 9'h180;
   localparam logic [8:0] ADDR_TIMER_PRESCALE_CONFIG = 9'h181;
   localparam logic [8:0] ADDR_PROGRAM_COUNTER_LOW = 9'h182;
   localparam logic [8:0] ADDR_CORE_STATUS_FLAGS = 9'h183;
   localparam logic [8:0] ADDR_INDIRECT_POINTER = 9'h184;
   localparam logic [8:0] ADDR_PORT_A_DIRECTION = 9'h185;
   localparam logic [8:0] ADDR_PORT_C_DIRECTION = 9'h187;
   localparam logic [8:0] ADDR_PROGRAM_COUNTER_HIGH_BUFFER = 9'h18A;
   localparam logic [8:0] ADDR_INTERRUPT_CONTROL = 9'h18B;
   // Status field positions
   localparam int BIT_INDIRECT_BANK_SELECT = 7;
   localparam int BIT_DIRECT_BANK_SELECT_HIGH = 6;
   localparam int BIT_DIRECT_BANK_SELECT_LOW = 5;
   localparam int BIT_WATCHDOG_TIMEOUT_FLAG = 4;
   localparam int BIT_POWERDOWN_FLAG = 3;
   localparam int BIT_ZERO_FLAG = 2;
   localparam int BIT_NIBBLE_CARRY_FLAG = 1;
   localparam int BIT_CARRY_FLAG = 0;
   // Power-up value of status; low three flags unknown, held at zero here
   localparam logic [7:0] RST_CORE_STATUS_FLAGS = 8'h18;
   // Other bank-3 reset values
   localparam logic [7:0] RST_TIMER_PRESCALE_CONFIG = 8'hFF;
   localparam logic [7:0] RST_PROGRAM_COUNTER_LOW = 8'h00;
   localparam logic [7:0] RST_INDIRECT_POINTER = 8'h00;
   localparam logic [5:0] RST_PORT_DIRECTION = 6'h3F;
   localparam logic [4:0] RST_PROGRAM_COUNTER_HIGH_BUFFER = 5'h00;
   localparam logic [7:0] RST_INTERRUPT_CONTROL = 8'h00;
   // Flag-update operation classes from the execution unit
   typedef enum logic [5:0] {
      CSSB_OP_NONE = 6'b000001, // No flag change
      CSSB_OP_ZERO = 6'b000010, // Logic op: zero flag only
      CSSB_OP_ADD = 6'b000100, // Add: zero, nibble carry, carry
      CSSB_OP_SUB = 6'b001000, // Subtract: a minus b
      CSSB_OP_ROTR = 6'b010000, // Rotate right through carry
      CSSB_OP_ROTL = 6'b100000 // Rotate left through carry
   } cssb_op_t;
endpackage

/* File: design/cssb_core.sv */
// Core status register, bank select and bank-3 register view
//
// Contract
// - Flag-updating op writing status keeps written zero/nibble-carry/carry bits out.
// - Timeout and power-down flags ignore software writes entirely.
// - Clear-file on status clears bank bits, sets zero, keeps others.
// - Indirect bank bit set selects banks 2-3, clear selects 0-1.
// - Direct bank field bits 6-5 picks bank 0 to 3.
// - Timeout flag set by power-up, watchdog clear, sleep; cleared by timeout.
// - Power-down flag set by power-up or watchdog clear; cleared by sleep.
// - Zero flag set when the result is zero, else cleared.
// - Nibble carry set on carry out of low nibble for add/subtract.
// - Carry set on carry out of bit 7 for add/subtract.
// - Subtract adds two's complement; carries mean no borrow.
// - Rotates load carry with the bit shifted out.
// - Power-up: bank bits 0, timeout and power-down 1.
// - Unimplemented addresses in the bank read zero.
// - Pin and watchdog resets clear the port-change latch; flag re-sets on mismatch.
`timescale 1ns/1ps
module cssb_core (
   input wire logic clk, // Instruction clock, 10 MHz
   input wire logic rstn, // Power-on/brown-out reset, active low
   input wire logic warm_rstn, // Pin or watchdog reset, active low
   input wire logic [8:0] reg_addr, // Register address for read/write
   input wire logic reg_wr, // Register write strobe
   input wire logic [7:0] reg_wdata, // Register write data
   output logic [7:0] reg_rdata, // Register read data
   input wire logic clear_file_instr, // Clear-file instruction on reg_addr
   input wire cssb_pkg::cssb_op_t alu_op, // Flag update class of current op
   input wire logic [7:0] alu_a, // First operand
   input wire logic [7:0] alu_b, // Second operand
   output logic [7:0] alu_result, // Operation result
   input wire logic watchdog_clear_instr, // Watchdog clear executes
   input wire logic sleep_instr, // Sleep executes
   input wire logic watchdog_timeout, // Watchdog timer expired
   input wire logic port_mismatch, // Port input differs from latch
   input wire logic [6:0] direct_addr, // Instruction file address
   output logic [8:0] data_addr_direct, // Banked direct address
   output logic [8:0] data_addr_indirect, // Banked indirect address
   output logic indirect_bank_select, // Status bit 7
   output logic [1:0] direct_bank_select // Status bits 6-5
);
   logic [7:0] core_status_flags;
   logic [7:0] timer_prescale_config;
   logic [7:0] program_counter_low;
   logic [7:0] indirect_pointer;
   logic [5:0] port_a_direction;
   logic [5:0] port_c_direction;
   logic [4:0] program_counter_high_buffer;
   logic [7:0] interrupt_control;
   logic [7:0] next_status;
   logic [8:0] sum9;
   logic [4:0] sum5;
   logic res_carry;
   logic res_nibble;
   logic flags_arith;
   logic flags_zero_only;
   logic flags_rotate;
   logic sel_status;
   logic sel_option;
   logic sel_pcl;
   logic sel_ptr;
   logic sel_dira;
   logic sel_dirc;
   logic sel_pch;
   logic sel_intc;
   logic wr_status;
   logic wr_option;
   logic wr_pcl;
   logic wr_ptr;
   logic wr_dira;
   logic wr_dirc;
   logic wr_pch;
   logic wr_intc;
   logic is_add;
   logic is_sub;
   logic is_zero_op;
   logic is_rotr;
   logic is_rotl;
   logic [7:0] b_eff;
   logic cin;
   logic intc_set;

   // Address decode
   assign sel_status = reg_addr == cssb_pkg::ADDR_CORE_STATUS_FLAGS;
   assign sel_option = reg_addr == cssb_pkg::ADDR_TIMER_PRESCALE_CONFIG;
   assign sel_pcl = reg_addr == cssb_pkg::ADDR_PROGRAM_COUNTER_LOW;
   assign sel_ptr = reg_addr == cssb_pkg::ADDR_INDIRECT_POINTER;
   assign sel_dira = reg_addr == cssb_pkg::ADDR_PORT_A_DIRECTION;
   assign sel_dirc = reg_addr == cssb_pkg::ADDR_PORT_C_DIRECTION;
   assign sel_pch = reg_addr == cssb_pkg::ADDR_PROGRAM_COUNTER_HIGH_BUFFER;
   assign sel_intc = reg_addr == cssb_pkg::ADDR_INTERRUPT_CONTROL;

   // Write strobes per register
   assign wr_status = reg_wr && sel_status;
   assign wr_option = reg_wr && sel_option;
   assign wr_pcl = reg_wr && sel_pcl;
   assign wr_ptr = reg_wr && sel_ptr;
   assign wr_dira = reg_wr && sel_dira;
   assign wr_dirc = reg_wr && sel_dirc;
   assign wr_pch = reg_wr && sel_pch;
   assign wr_intc = reg_wr && sel_intc;

   // Operation class decode
   assign is_add = alu_op == cssb_pkg::CSSB_OP_ADD;
   assign is_sub = alu_op == cssb_pkg::CSSB_OP_SUB;
   assign is_zero_op = alu_op == cssb_pkg::CSSB_OP_ZERO;
   assign is_rotr = alu_op == cssb_pkg::CSSB_OP_ROTR;
   assign is_rotl = alu_op == cssb_pkg::CSSB_OP_ROTL;

   // Adder; subtract adds inverted b plus one
   assign b_eff = is_sub ? ~alu_b : alu_b;
   assign cin = is_sub;
   assign sum9 = {1'b0, alu_a} + {1'b0, b_eff} + {8'h00, cin};
   assign sum5 = {1'b0, alu_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
   assign res_carry = sum9[8];
   assign res_nibble = sum5[4];
   assign flags_arith = is_add || is_sub;
   assign flags_zero_only = is_zero_op;
   assign flags_rotate = is_rotr || is_rotl;

   // Result mux
   always_comb begin
      unique case (alu_op)
         cssb_pkg::CSSB_OP_ADD,
         cssb_pkg::CSSB_OP_SUB: alu_result = sum9[7:0];
         cssb_pkg::CSSB_OP_ROTR: alu_result =
            {core_status_flags[cssb_pkg::BIT_CARRY_FLAG], alu_a[7:1]};
         cssb_pkg::CSSB_OP_ROTL: alu_result =
            {alu_a[6:0], core_status_flags[cssb_pkg::BIT_CARRY_FLAG]};
         default: alu_result = alu_a;
      endcase
   end

   // Next status value
   always_comb begin
      next_status = core_status_flags;
      if (clear_file_instr && sel_status) begin
         next_status[7:5] = 3'b000;
         next_status[cssb_pkg::BIT_ZERO_FLAG] = 1'b1;
      end else if (wr_status) begin
         next_status[7:5] = reg_wdata[7:5];
         // Any flag op blocks all three low flags; untouched ones hold
         if (!(flags_arith || flags_zero_only || flags_rotate)) begin
            next_status[2:0] = reg_wdata[2:0];
         end
      end
      // Flag updates from the operation override the data write
      if (flags_arith || flags_zero_only) begin
         next_status[cssb_pkg::BIT_ZERO_FLAG] = alu_result == 8'h00;
      end
      if (flags_arith) begin
         next_status[cssb_pkg::BIT_NIBBLE_CARRY_FLAG] = res_nibble;
         next_status[cssb_pkg::BIT_CARRY_FLAG] = res_carry;
      end
      if (is_rotr) begin
         next_status[cssb_pkg::BIT_CARRY_FLAG] = alu_a[0];
      end
      if (is_rotl) begin
         next_status[cssb_pkg::BIT_CARRY_FLAG] = alu_a[7];
      end
      // Hardware-only reset-cause flags
      if (watchdog_clear_instr) begin
         next_status[cssb_pkg::BIT_WATCHDOG_TIMEOUT_FLAG] = 1'b1;
         next_status[cssb_pkg::BIT_POWERDOWN_FLAG] = 1'b1;
      end else if (sleep_instr) begin
         next_status[cssb_pkg::BIT_WATCHDOG_TIMEOUT_FLAG] = 1'b1;
         next_status[cssb_pkg::BIT_POWERDOWN_FLAG] = 1'b0;
      end
      if (watchdog_timeout) begin
         next_status[cssb_pkg::BIT_WATCHDOG_TIMEOUT_FLAG] = 1'b0;
      end
   end

   // Status register; warm reset clears bank bits only
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         core_status_flags <= cssb_pkg::RST_CORE_STATUS_FLAGS;
      end else if (!warm_rstn) begin
         core_status_flags <= {3'b000, core_status_flags[4:0]};
      end else begin
         core_status_flags <= next_status;
      end
   end

   // Port-change flag: cleared on warm reset, re-set while mismatch stays
   assign intc_set = port_mismatch;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         interrupt_control <= cssb_pkg::RST_INTERRUPT_CONTROL;
      end else if (!warm_rstn) begin
         interrupt_control <= cssb_pkg::RST_INTERRUPT_CONTROL;
      end else begin
         interrupt_control <= wr_intc ? reg_wdata : interrupt_control;
         if (intc_set) begin
            interrupt_control[0] <= 1'b1;
         end
      end
   end

   // Prescaler configuration; all ones after any reset
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         timer_prescale_config <= cssb_pkg::RST_TIMER_PRESCALE_CONFIG;
      end else if (!warm_rstn) begin
         timer_prescale_config <= cssb_pkg::RST_TIMER_PRESCALE_CONFIG;
      end else if (wr_option) begin
         timer_prescale_config <= reg_wdata;
      end
   end

   // Program counter low byte
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         program_counter_low <= cssb_pkg::RST_PROGRAM_COUNTER_LOW;
      end else if (!warm_rstn) begin
         program_counter_low <= cssb_pkg::RST_PROGRAM_COUNTER_LOW;
      end else if (wr_pcl) begin
         program_counter_low <= reg_wdata;
      end
   end

   // Indirect pointer; survives warm reset
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         indirect_pointer <= cssb_pkg::RST_INDIRECT_POINTER;
      end else if (wr_ptr) begin
         indirect_pointer <= reg_wdata;
      end
   end

   // Port A direction, six bits
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         port_a_direction <= cssb_pkg::RST_PORT_DIRECTION;
      end else if (!warm_rstn) begin
         port_a_direction <= cssb_pkg::RST_PORT_DIRECTION;
      end else if (wr_dira) begin
         port_a_direction <= reg_wdata[5:0];
      end
   end

   // Port C direction, six bits
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         port_c_direction <= cssb_pkg::RST_PORT_DIRECTION;
      end else if (!warm_rstn) begin
         port_c_direction <= cssb_pkg::RST_PORT_DIRECTION;
      end else if (wr_dirc) begin
         port_c_direction <= reg_wdata[5:0];
      end
   end

   // Program counter high write buffer, five bits
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         program_counter_high_buffer <= cssb_pkg::RST_PROGRAM_COUNTER_HIGH_BUFFER;
      end else if (!warm_rstn) begin
         program_counter_high_buffer <= cssb_pkg::RST_PROGRAM_COUNTER_HIGH_BUFFER;
      end else if (wr_pch) begin
         program_counter_high_buffer <= reg_wdata[4:0];
      end
   end

   // Read mux; unmapped and indirect port read zero here
   always_comb begin
      reg_rdata = 8'h00;
      if (sel_status) reg_rdata = core_status_flags;
      if (sel_option) reg_rdata = timer_prescale_config;
      if (sel_pcl) reg_rdata = program_counter_low;
      if (sel_ptr) reg_rdata = indirect_pointer;
      if (sel_dira) reg_rdata = {2'b00, port_a_direction};
      if (sel_dirc) reg_rdata = {2'b00, port_c_direction};
      if (sel_pch) reg_rdata = {3'b000, program_counter_high_buffer};
      if (sel_intc) reg_rdata = interrupt_control;
   end

   // Bank selection for the data-memory decoder
   assign indirect_bank_select = core_status_flags[cssb_pkg::BIT_INDIRECT_BANK_SELECT];
   assign direct_bank_select = core_status_flags[6:5];
   assign data_addr_direct = {direct_bank_select, direct_addr};
   assign data_addr_indirect = {indirect_bank_select, indirect_pointer};
endmodule // cssb_core

/* File: tb/cssb_core_monitor.sv */
// Assertion checker for the status register block
`timescale 1ns/1ps
module cssb_core_monitor (
   input wire logic clk, // Clock
   input wire logic rstn, // Power-on reset
   input wire logic warm_rstn, // Warm reset
   input wire logic [8:0] reg_addr, // Address
   input wire logic reg_wr, // Write strobe
   input wire logic [7:0] reg_wdata, // Write data
   input wire logic [7:0] reg_rdata, // Read data
   input wire logic clear_file_instr, // Clear-file
   input wire logic watchdog_clear_instr, // Watchdog clear
   input wire logic sleep_instr, // Sleep
   input wire logic watchdog_timeout, // Timeout
   input wire logic [6:0] direct_addr, // File address
   input wire logic [8:0] data_addr_direct, // Direct address
   input wire logic [8:0] data_addr_indirect, // Indirect address
   input wire logic indirect_bank_select, // Bit 7
   input wire logic [1:0] direct_bank_select // Bits 6-5
);
   localparam logic [8:0] ST = cssb_pkg::ADDR_CORE_STATUS_FLAGS;
   wire quiet = !watchdog_clear_instr && !sleep_instr && !watchdog_timeout;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // Address forming, bank writes and clears, read-only flags
   property p_dir_addr; data_addr_direct == {direct_bank_select, direct_addr}; endproperty
   a_dir_addr: assert property (p_dir_addr) else $error("direct address wrong");
   property p_ind_bank; data_addr_indirect[8] == indirect_bank_select; endproperty
   a_ind_bank: assert property (p_ind_bank) else $error("indirect bank wrong");
   property p_wr_bank; reg_wr && reg_addr == ST && !clear_file_instr && warm_rstn
      |=> {indirect_bank_select, direct_bank_select} == $past(reg_wdata[7:5]); endproperty
   a_wr_bank: assert property (p_wr_bank) else $error("bank write lost");
   property p_clr_bank; clear_file_instr && reg_addr == ST
      |=> {indirect_bank_select, direct_bank_select} == 3'h0; endproperty
   a_clr_bank: assert property (p_clr_bank) else $error("clear kept bank");
   property p_keep_ro; reg_wr && reg_addr == ST && quiet ##1 reg_addr == ST
      |-> reg_rdata[4:3] == $past(reg_rdata[4:3]); endproperty
   a_keep_ro: assert property (p_keep_ro) else $error("reset flags written");
   property p_timeout; watchdog_timeout ##1 reg_addr == ST |-> !reg_rdata[4]; endproperty
   a_timeout: assert property (p_timeout) else $error("timeout flag not cleared");
   property p_sleep; sleep_instr && !watchdog_timeout && !watchdog_clear_instr
      ##1 reg_addr == ST |-> reg_rdata[4:3] == 2'b10; endproperty
   a_sleep: assert property (p_sleep) else $error("sleep flags wrong");
   property p_unmapped; reg_addr inside {9'h186, 9'h188, 9'h189, [9'h18C:9'h19F]}
      |-> reg_rdata == 8'h00; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule // cssb_core_monitor
bind cssb_core cssb_core_monitor cssb_core_monitor_i (.clk, .rstn, .warm_rstn, .reg_addr,
   .reg_wr, .reg_wdata, .reg_rdata, .clear_file_instr, .watchdog_clear_instr, .sleep_instr,
   .watchdog_timeout, .direct_addr, .data_addr_direct, .data_addr_indirect,
   .indirect_bank_select, .direct_bank_select);

/* File: tb/tb_cssb_core.sv */
// Self-checking testbench for the status register block
`timescale 1ns/1ps
module tb_cssb_core;
   localparam logic [8:0] ST = cssb_pkg::ADDR_CORE_STATUS_FLAGS;
   logic clk, rstn, warm_rstn, reg_wr, clear_file_instr, port_mismatch, indirect_bank_select;
   logic watchdog_clear_instr, sleep_instr, watchdog_timeout;
   logic [8:0] reg_addr, data_addr_direct, data_addr_indirect;
   logic [7:0] reg_wdata, reg_rdata, alu_a, alu_b, alu_result;
   logic [6:0] direct_addr;
   logic [1:0] direct_bank_select;
   cssb_pkg::cssb_op_t alu_op;
   int err_total = 0, checks_done = 0, cycles = 0;
   logic [8:0] ra [8] = '{9'h181, 9'h182, 9'h185, 9'h187, 9'h18A, 9'h186, 9'h18C, 9'h19F};
   logic [7:0] rv [8] = '{8'hFF, 8'h00, 8'h3F, 8'h3F, 8'h00, 8'h00, 8'h00, 8'h00};
   // Operation table: class, operands, result, expected zero/nibble/carry
   cssb_pkg::cssb_op_t top [10] = '{cssb_pkg::CSSB_OP_ADD, cssb_pkg::CSSB_OP_ADD,
      cssb_pkg::CSSB_OP_ADD, cssb_pkg::CSSB_OP_SUB, cssb_pkg::CSSB_OP_SUB, cssb_pkg::CSSB_OP_SUB,
      cssb_pkg::CSSB_OP_ROTL, cssb_pkg::CSSB_OP_ROTR, cssb_pkg::CSSB_OP_ROTR, cssb_pkg::CSSB_OP_ZERO};
   logic [7:0] ta [10] = '{8'h0F, 8'hF0, 8'h01, 8'h05, 8'h10, 8'h00, 8'h80, 8'h02, 8'h01, 8'h00};
   logic [7:0] tb [10] = '{8'h01, 8'h10, 8'h01, 8'h05, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [7:0] tr [10] = '{8'h10, 8'h00, 8'h02, 8'h00, 8'h0F, 8'hFF, 8'h00, 8'h81, 8'h00, 8'h00};
   logic [2:0] tf [10] = '{3'h2, 3'h5, 3'h0, 3'h7, 3'h1, 3'h0, 3'h1, 3'h0, 3'h1, 3'h5};
   cssb_core cssb_core_i (.clk, .rstn, .warm_rstn, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata,
      .clear_file_instr, .alu_op, .alu_a, .alu_b, .alu_result, .watchdog_clear_instr,
      .sleep_instr, .watchdog_timeout, .port_mismatch, .direct_addr, .data_addr_direct,
      .data_addr_indirect, .indirect_bank_select, .direct_bank_select);
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Compare and count
   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // One cycle of all execution inputs, driven at the rising edge
   task automatic go(input logic [8:0] a, input logic w, input logic [7:0] d,
         input cssb_pkg::cssb_op_t op, input logic [7:0] x, input logic [7:0] y,
         input logic [3:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_wr <= w;
      reg_wdata <= d;
      alu_op <= op;
      alu_a <= x;
      alu_b <= y;
      {clear_file_instr, watchdog_clear_instr, sleep_instr, watchdog_timeout} <= e;
   endtask
   task automatic ev(input logic [3:0] e);
      go(ST, 1'b0, 8'h00, cssb_pkg::CSSB_OP_NONE, 8'h00, 8'h00, e);
   endtask
   task automatic wr(input logic [8:0] a, input logic [7:0] d);
      go(a, 1'b1, d, cssb_pkg::CSSB_OP_NONE, 8'h00, 8'h00, 4'h0);
   endtask
   task automatic rd(input logic [8:0] a, input logic [7:0] e);
      go(a, 1'b0, 8'h00, cssb_pkg::CSSB_OP_NONE, 8'h00, 8'h00, 4'h0);
      #10;
      chk({1'b0, reg_rdata}, {1'b0, e});
   endtask
   task automatic final_report;
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // Hang guard
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         err_total++;
         final_report();
      end
   end
   // Main sequence
   initial begin
      {reg_wr, clear_file_instr, watchdog_clear_instr, sleep_instr, watchdog_timeout} = '0;
      {port_mismatch, rstn, reg_wdata, alu_a, alu_b} = '0;
      alu_op = cssb_pkg::CSSB_OP_NONE;
      reg_addr = ST;
      warm_rstn = 1'b1;
      direct_addr = 7'h55;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      rd(ST, 8'h18);
      for (int i = 0; i < 8; i++) rd(ra[i], rv[i]);
      wr(9'h184, 8'hA5);
      for (int b = 0; b < 8; b++) begin
         wr(ST, {b[2:0], 5'h00});
         rd(ST, {b[2:0], 5'h18});
         chk(data_addr_direct, {b[1:0], 7'h55});
         chk(data_addr_indirect, {b[2], 8'hA5});
      end
      wr(ST, 8'hE5);
      ev(4'h8);
      rd(ST, 8'h1D);
      for (int i = 0; i < 10; i++) begin
         go(ST, 1'b1, {5'h00, ~tf[i]}, top[i], ta[i], tb[i], 4'h0);
         #10;
         chk({1'b0, alu_result}, {1'b0, tr[i]});
         rd(ST, {5'h03, tf[i]});
      end
      ev(4'h2);
      rd(ST, 8'h15);
      ev(4'h1);
      rd(ST, 8'h05);
      ev(4'h4);
      rd(ST, 8'h1D);
      wr(ST, 8'hE0);
      wr(9'h18B, 8'h54);
      wr(9'h181, 8'h00);
      ev(4'h0);
      warm_rstn <= 1'b0;
      port_mismatch <= 1'b1;
      @(posedge clk);
      warm_rstn <= 1'b1;
      rd(9'h18B, 8'h01);
      rd(ST, 8'h18);
      rd(9'h181, 8'hFF);
      rd(9'h184, 8'hA5);
      final_report();
   end
endmodule // tb_cssb_core
